// file: logic/eir_regs.vh
`ifndef EIR_REGS_VH
`define EIR_REGS_VH
// Trigger option codes
`define EIR_MODE_EDGE        1'b0
`define EIR_MODE_EDGE_LEVEL  1'b1
// Minimum low time on the request pin, in ns, and its cycle count (rounded up)
`define EIR_MIN_LOW_NS       120
`define EIR_CLK_NS           40
`define EIR_MIN_LOW_CYC      ((`EIR_MIN_LOW_NS + `EIR_CLK_NS - 1) / `EIR_CLK_NS)
`define EIR_CNT_W            4
// Power-on stretch before the core leaves reset, in cycles
`define EIR_POR_CYC          4
// Internal clock divide ratio
`define EIR_DIV_RATIO        2
`endif

// file: logic/eir_sync.v
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module eir_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire arst_n,
  // Data
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// file: logic/eir_irq.v
`timescale 1ns/1ps
`include "eir_regs.vh"

// Summary of operation
// - Fixed option selects falling edge only, or falling edge plus low level.
// - Request pin low for the minimum time sets the pending latch.
// - A pending request is acted upon only after the current instruction ends.
// - At instruction end, latch set and mask clear starts the interrupt sequence.
// - Internal clock enable is the oscillator rate divided by two.
// - Works from power-on reset; external reset holds the core and clears the pending latch and clock enable, but not the request qualifier.
module eir_irq #(
  parameter TRIG_MODE = `EIR_MODE_EDGE_LEVEL
) (
  // Clock and reset
  input  wire ref_clk,
  input  wire arst_n,
  // External reset pin, active low
  input  wire ext_reset_n,
  // Request pin, active low
  input  wire irq_n,
  // CPU sequencer
  input  wire instr_done,
  input  wire int_mask,
  output wire int_take,
  output reg  irq_pending_q,
  output reg  cpu_clk_en_q,
  output reg  core_reset_q
);
  localparam integer          MIN_LOW_I = `EIR_MIN_LOW_CYC;
  localparam integer          POR_I     = `EIR_POR_CYC;
  localparam [`EIR_CNT_W-1:0] MIN_LOW   = MIN_LOW_I[`EIR_CNT_W-1:0];
  localparam [`EIR_CNT_W-1:0] POR_LEN   = POR_I[`EIR_CNT_W-1:0];
  localparam [`EIR_CNT_W-1:0] CNT_ZERO  = 4'h0;
  localparam [`EIR_CNT_W-1:0] CNT_ONE   = 4'h1;

  // Qualification states of the request line
  localparam [1:0]            ST_HIGH   = 2'h0;
  localparam [1:0]            ST_ARMED  = 2'h1;
  localparam [1:0]            ST_SPENT  = 2'h2;

  // Synchroniser lanes: bit 0 request pin, bit 1 reset pin
  wire [1:0]                  pin_raw;
  wire [1:0]                  pin_s;
  wire                        irq_s;
  wire                        rst_s;

  // Power-on reset stretch
  reg  [`EIR_CNT_W-1:0]       por_cnt_q;
  wire                        por_done;

  // Low-time qualification
  reg  [`EIR_CNT_W-1:0]       low_cnt_q;
  reg  [`EIR_CNT_W-1:0]       low_cnt_d;
  reg  [1:0]                  qual_q;
  reg  [1:0]                  qual_d;
  wire                        low_ok;
  wire                        edge_req;
  wire                        level_req;
  wire                        level_mode;
  wire                        set_req;

  // Instruction boundary test
  wire                        at_boundary;
  wire                        may_take;
  reg                         pending_d;

  ////////////////////////////////////////////////////////////////////////
  // True while the qualifier has seen the line low
  function line_low;
    input [1:0] st;
    begin
      case (st)
        ST_ARMED: begin
          line_low = 1'b1;
        end
        ST_SPENT: begin
          line_low = 1'b1;
        end
        default: begin
          line_low = 1'b0;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign pin_raw = {ext_reset_n, irq_n};

  genvar g;

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      eir_sync u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .din     (pin_raw[g]),
        .dout    (pin_s[g])
      );
    end
  endgenerate

  assign irq_s = pin_s[0];
  assign rst_s = pin_s[1];

  ////////////////////////////////////////////////////////////////////////
  // Counts a few cycles after power-on before letting the core run
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt_q <= CNT_ZERO;
    end else if (!por_done) begin
      por_cnt_q <= por_cnt_q + CNT_ONE;
    end
  end

  assign por_done = (por_cnt_q == POR_LEN);

  // External reset held low, or power-on stretch, holds the core
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_reset_q <= 1'b1;
    end else begin
      core_reset_q <= ~rst_s | ~por_done;
    end
  end

  // Divide by two enable
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk_en_q <= 1'b0;
    end else if (core_reset_q) begin
      cpu_clk_en_q <= 1'b0;
    end else begin
      cpu_clk_en_q <= ~cpu_clk_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-time counter restarts whenever the line returns high
  always @* begin
    low_cnt_d = low_cnt_q;
    if (irq_s) begin
      low_cnt_d = CNT_ZERO;
    end else if (!line_low(qual_q)) begin
      low_cnt_d = CNT_ONE;
    end else if (low_cnt_q < MIN_LOW) begin
      low_cnt_d = low_cnt_q + CNT_ONE;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_q <= CNT_ZERO;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end

  // Edge is used up once per low period
  always @* begin
    qual_d = qual_q;
    case (qual_q)
      ST_HIGH: begin
        if (!irq_s) begin
          qual_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (irq_s) begin
          qual_d = ST_HIGH;
        end else if (low_ok) begin
          qual_d = ST_SPENT;
        end
      end
      ST_SPENT: begin
        if (irq_s) begin
          qual_d = ST_HIGH;
        end
      end
      default: begin
        qual_d = ST_HIGH;
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      qual_q <= ST_HIGH;
    end else begin
      qual_q <= qual_d;
    end
  end

  assign low_ok     = line_low(qual_q) && ~irq_s && (low_cnt_q >= MIN_LOW);
  assign level_mode = (TRIG_MODE == `EIR_MODE_EDGE_LEVEL);
  assign edge_req   = low_ok && (qual_q == ST_ARMED);
  assign level_req  = low_ok && level_mode;
  assign set_req    = edge_req | level_req;

  ////////////////////////////////////////////////////////////////////////
  // Tested only at instruction end, on the internal clock enable
  assign at_boundary = instr_done && cpu_clk_en_q;
  assign may_take    = irq_pending_q && ~int_mask;
  assign int_take    = at_boundary && may_take && ~core_reset_q;

  // A new request in the take cycle wins over the clear
  always @* begin
    pending_d = irq_pending_q;
    if (core_reset_q) begin
      pending_d = 1'b0;
    end else if (set_req) begin
      pending_d = 1'b1;
    end else if (int_take) begin
      pending_d = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_pending_q <= 1'b0;
    end else begin
      irq_pending_q <= pending_d;
    end
  end
endmodule

// file: bench/eir_src.sv
`timescale 1ns/1ps
module eir_src (
  input  wire [1:0] req,
  output wire       irq_n
);
  // Each source only pulls the shared line low; released it floats high
  assign irq_n = ~|req;
endmodule

// file: bench/eir_irq_monitor.sv
`timescale 1ns/1ps
module eir_irq_monitor (
  input ref_clk,
  input arst_n,
  input instr_done,
  input int_mask,
  input int_take,
  input irq_pending_q,
  input cpu_clk_en_q,
  input core_reset_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_take_cause: assert property (int_take |-> irq_pending_q && !int_mask && cpu_clk_en_q) else $error("bad");
  a_take_due: assert property (instr_done && cpu_clk_en_q && irq_pending_q && !int_mask && !core_reset_q |-> int_take)
    else $error("no take");
  a_clk_half: assert property (!core_reset_q [*2] |-> !$stable(cpu_clk_en_q)) else $error("stuck");
  a_reset_clear: assert property (core_reset_q [*2] |-> !irq_pending_q && !cpu_clk_en_q) else $error("held");
  a_take_boundary: assert property (int_take |-> instr_done) else $error("take off boundary");
  a_take_reset: assert property (core_reset_q |-> !int_take) else $error("take in reset");
  a_pend_hold: assert property (irq_pending_q && !int_take && !core_reset_q |=> irq_pending_q)
    else $error("pending lost");
endmodule

// file: bench/eir_irq_test.sv
`timescale 1ns/1ps
module eir_irq_test;
  reg        ref_clk     = 1'h0;
  reg        arst_n      = 1'h0;
  reg        ext_reset_n = 1'h1;
  reg        instr_done  = 1'h0;
  reg        int_mask    = 1'h0;
  reg  [1:0] req         = 2'h0;
  wire       irq_n;
  wire       int_take;
  wire       irq_pending_q;
  wire       cpu_clk_en_q;
  wire       core_reset_q;
  wire       int_take_e;
  wire       irq_pending_e;
  integer    fail_count  = 0;
  integer    n_tests     = 0;
  integer    i;
  reg        en_prev;
  reg        seen;

  always #20 ref_clk = ~ref_clk;

  eir_src i_eir_src (
    .req   (req),
    .irq_n (irq_n)
  );

  // Edge plus level trigger
  eir_irq #(.TRIG_MODE(1'h1)) i_eir_irq (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .ext_reset_n   (ext_reset_n),
    .irq_n         (irq_n),
    .instr_done    (instr_done),
    .int_mask      (int_mask),
    .int_take      (int_take),
    .irq_pending_q (irq_pending_q),
    .cpu_clk_en_q  (cpu_clk_en_q),
    .core_reset_q  (core_reset_q)
  );

  // Edge-only trigger on the same line
  eir_irq #(.TRIG_MODE(1'h0)) i_eir_irq_edge (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .ext_reset_n   (ext_reset_n),
    .irq_n         (irq_n),
    .instr_done    (instr_done),
    .int_mask      (int_mask),
    .int_take      (int_take_e),
    .irq_pending_q (irq_pending_e),
    .cpu_clk_en_q  (),
    .core_reset_q  ()
  );

  task final_report;
    begin
      $display("%0d checks, %0d mismatches", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  task chk;
    input v;
    input e;
    begin
      n_tests = n_tests + 1;
      if (v !== e) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0t wrong value", $time);
      end
    end
  endtask

  // Bounded wait for both pending latches
  task wait_pend;
    input el;
    input ee;
    begin
      i = 0;
      while (i < 16 && (irq_pending_q !== el || irq_pending_e !== ee)) begin
        @(negedge ref_clk);
        i = i + 1;
      end
      if (i == 16) begin
        fail_count = fail_count + 1;
        final_report;
      end
    end
  endtask

  // Bounded wait for the core reset output
  task wait_rst;
    input v;
    begin
      i = 0;
      while (i < 16 && core_reset_q !== v) begin
        @(negedge ref_clk);
        i = i + 1;
      end
      if (i == 16) begin
        fail_count = fail_count + 1;
        final_report;
      end
    end
  endtask

  // One instruction end spanning both enable phases
  task take;
    input m;
    input el;
    input ee;
    begin
      seen = 1'h0;
      @(posedge ref_clk);
      instr_done <= 1'h1;
      int_mask   <= m;
      repeat (2) begin
        @(negedge ref_clk);
        if (cpu_clk_en_q === 1'h1) begin
          seen = 1'h1;
          chk(int_take, el);
          chk(int_take_e, ee);
        end
      end
      chk(seen, 1'h1);
      @(posedge ref_clk);
      instr_done <= 1'h0;
      int_mask   <= 1'h0;
    end
  endtask

  task s_div;
    begin
      @(negedge ref_clk);
      chk(core_reset_q, 1'h0);
      en_prev = cpu_clk_en_q;
      repeat (4) begin
        @(negedge ref_clk);
        chk(cpu_clk_en_q, ~en_prev);
        en_prev = cpu_clk_en_q;
      end
    end
  endtask

  task s_level_edge;
    begin
      @(posedge ref_clk);
      req <= 2'h1;
      wait_pend(1'h1, 1'h1);
      chk(irq_pending_q, 1'h1);
      take(1'h1, 1'h0, 1'h0);
      @(negedge ref_clk);
      chk(irq_pending_q, 1'h1);
      chk(irq_pending_e, 1'h1);
      take(1'h0, 1'h1, 1'h1);
      @(negedge ref_clk);
      chk(irq_pending_q, 1'h1);
      chk(irq_pending_e, 1'h0);
      take(1'h0, 1'h1, 1'h0);
      @(posedge ref_clk);
      req <= 2'h0;
      repeat (8) @(posedge ref_clk);
      take(1'h0, 1'h1, 1'h0);
      @(negedge ref_clk);
      chk(irq_pending_q, 1'h0);
      chk(irq_pending_e, 1'h0);
    end
  endtask

  task s_short;
    begin
      @(posedge ref_clk);
      req <= 2'h1;
      @(posedge ref_clk);
      req <= 2'h0;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(irq_pending_q, 1'h0);
      chk(irq_pending_e, 1'h0);
    end
  endtask

  task s_second;
    begin
      @(posedge ref_clk);
      req <= 2'h2;
      wait_pend(1'h1, 1'h1);
      chk(irq_pending_e, 1'h1);
      @(posedge ref_clk);
      req <= 2'h0;
      repeat (8) @(posedge ref_clk);
      take(1'h0, 1'h1, 1'h1);
      @(negedge ref_clk);
      chk(irq_pending_q, 1'h0);
      chk(irq_pending_e, 1'h0);
    end
  endtask

  task s_reset;
    begin
      @(posedge ref_clk);
      req <= 2'h1;
      wait_pend(1'h1, 1'h1);
      @(posedge ref_clk);
      ext_reset_n <= 1'h0;
      wait_rst(1'h1);
      @(negedge ref_clk);
      chk(core_reset_q, 1'h1);
      chk(irq_pending_q, 1'h0);
      chk(irq_pending_e, 1'h0);
      chk(cpu_clk_en_q, 1'h0);
      @(posedge ref_clk);
      ext_reset_n <= 1'h1;
      req         <= 2'h0;
      wait_rst(1'h0);
      chk(core_reset_q, 1'h0);
    end
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (8) @(posedge ref_clk);
    s_div;
    s_level_edge;
    s_short;
    s_second;
    s_reset;
    final_report;
  end
endmodule

bind eir_irq eir_irq_monitor i_eir_irq_monitor (
  .ref_clk       (ref_clk),
  .arst_n        (arst_n),
  .instr_done    (instr_done),
  .int_mask      (int_mask),
  .int_take      (int_take),
  .irq_pending_q (irq_pending_q),
  .cpu_clk_en_q  (cpu_clk_en_q),
  .core_reset_q  (core_reset_q)
);
